//--- verilog/tw_pkg.sv
// Shared constants, divider table and timing functions for the two-wire bit timer
package tw_pkg;

  localparam logic [1:0] IDX_DIV  = 2'h0;
  localparam logic [1:0] IDX_CTRL = 2'h1;
  localparam logic [1:0] IDX_CMD  = 2'h2;
  localparam logic [1:0] IDX_STAT = 2'h3;

  localparam int DIV_CODE_LSB = 0;
  localparam int DIV_RATE_LSB = 8;
  localparam int CMD_BIT_POS  = 2;
  localparam int STAT_BST_POS = 5;
  localparam int STAT_BSP_POS = 6;

  localparam logic [5:0] RST_CODE = 6'h00;
  localparam logic [5:0] RST_RATE = 6'h01;

  localparam logic [16:0] STOP_SU_CLKS = 17'h00004;
  localparam logic [2:0]  STH_IN_MIN   = 3'h4;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_BIT   = 2'h1,
    OP_RSTRT = 2'h2,
    OP_STOP  = 2'h3
  } tw_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SHOLD = 3'h1,
    ST_PARK  = 3'h3,
    ST_LOWH  = 3'h2,
    ST_LOWS  = 3'h6,
    ST_RISE  = 3'h7,
    ST_HIGH  = 3'h5
  } tw_st_t;

  // Divider value per code, codes 0x00 to 0x3F
  localparam logic [15:0] DIV_TAB [0:63] = '{
    288, 320, 384, 448, 576, 640, 768, 896, 1152, 1280, 1536, 1792, 2304, 2560, 3072, 3584,
    4608, 5120, 6144, 7168, 9216, 10240, 12288, 14336, 18432, 20480, 24576, 28672, 36864,
    40960, 49152, 61440,
    160, 192, 224, 256, 320, 384, 480, 512, 640, 768, 960, 1024, 1280, 1536, 1920, 2048,
    2560, 3072, 3840, 4096, 5120, 6144, 7680, 8192, 10240, 12288, 15360, 16384, 20480,
    24576, 30720, 32768};

  // Data hold count from code
  function automatic logic [13:0] dh_of(input logic [5:0] c);
    logic [13:0] m;
    m = 14'h0000;
    case ({c[5], c[1]})
      2'b10:   m = 14'h0001;
      2'b11:   m = 14'h0002;
      2'b00:   m = 14'h0003;
      default: m = 14'h0004;
    endcase
    return 14'h0008 + (m << ({1'b0, c[4:2]} + 4'h4));
  endfunction

  // Start hold: divider/16 halved until under the limit
  function automatic logic [11:0] sth_of(input logic [5:0] c);
    logic [11:0] v;
    logic [11:0] lim;
    v   = DIV_TAB[c][15:4];
    lim = c[5] ? 12'h009 : 12'h010;
    for (int i = 0; i < 12; i++) begin
      if (v >= lim) begin
        v = v >> 1;
      end
    end
    return v;
  endfunction

endpackage

//--- verilog/tw_filt.sv
// Input qualifier: pin synchroniser plus sampled two-vote filter
`timescale 1ns/1ps
`default_nettype none
module tw_filt #(
  parameter int RW = 6
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic [RW-1:0] rate,
  input  wire logic          pin_i,
  output logic               qual
);
  logic [2:0]    sync_ff;
  logic          stab_ff;
  logic [RW-1:0] div_ff;
  logic          smp_ff;
  logic          q_ff;
  wire           smp_en = (div_ff == '0);
  wire  [RW-1:0] rate_m1 = (rate == '0) ? '0 : rate - 1'b1;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_ff <= 3'h7;
      stab_ff <= 1'b1;
      div_ff  <= '0;
      smp_ff  <= 1'b1;
      q_ff    <= 1'b1;
    end else begin
      sync_ff <= {sync_ff[1:0], pin_i};
      if (sync_ff[1] == sync_ff[2]) begin
        stab_ff <= sync_ff[2];
      end
      div_ff <= smp_en ? rate_m1 : div_ff - 1'b1;
      if (smp_en) begin
        smp_ff <= stab_ff;
        if (smp_ff == stab_ff) begin
          q_ff <= stab_ff;
        end
      end
    end
  end

  assign qual = q_ff;
endmodule
`default_nettype wire

//--- verilog/tw_core.sv
// Two-wire bit timer with input qualifier and Wishbone registers
// Contract
// - Qualify SCL and SDA by filter, lag up to period x (rate x 2 plus four), rate 0 counting as 1.
// - Six-bit code selects divider; master SCL low and high each half of it.
// - Code to divider map follows the fixed table, e.g. 0x20 gives 160.
// - Master data setup is half divider minus data hold before SCL rises.
// - Repeated start setup is full divider plus start hold.
// - At least 4 clocks of setup before a stop, both sides.
// - Start hold is divider/16 halved until below 16, or 9 when code[5] set.
// - Lines are only pulled low or released, never driven high.
// - Every divider value yields its own output bit rate.
// - Slave waits data hold after SCL low before stretching; start holds 4.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tw_core (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);
  logic [5:0]          bit_rate_divider_code_ff;
  logic [5:0]          input_filter_sample_rate_ff;
  logic                stretch_ff;
  tw_pkg::tw_op_t      op_ff;
  logic                bit_ff;
  logic                rx_ff;
  tw_pkg::tw_st_t      state_ff;
  tw_pkg::tw_st_t      nxt_state;
  logic [16:0]         cnt_ff;
  logic [16:0]         nxt_cnt;
  logic [15:0]         div_ff;
  logic [13:0]         dh_ff;
  logic [11:0]         sth_ff;
  logic                lim9_ff;
  logic                scl_pull_ff;
  logic                nxt_scl_pull;
  logic                sda_pull_ff;
  logic                nxt_sda_pull;
  logic                slv_arm_ff;
  logic                slv_hold_ff;
  logic [13:0]         slv_cnt_ff;
  logic                scl_d_ff;
  logic                sda_d_ff;
  logic                bus_busy_ff;
  logic                ev_start_ff;
  logic [2:0]          mon_ff;
  logic                bad_start_ff;
  logic                bad_stop_ff;
  logic                ack_ff;
  logic [31:0]         dat_ff;
  logic [16:0]         stay_ff;
  logic [13:0]         slv_len_ff;
  wire                 scl_q;
  wire                 sda_q;

  tw_filt #(.RW(6)) u_scl_filt (
    .clk     (clk),
    .sys_rst (sys_rst),
    .rate    (input_filter_sample_rate_ff),
    .pin_i   (scl_i),
    .qual    (scl_q)
  );

  tw_filt #(.RW(6)) u_sda_filt (
    .clk     (clk),
    .sys_rst (sys_rst),
    .rate    (input_filter_sample_rate_ff),
    .pin_i   (sda_i),
    .qual    (sda_q)
  );

  // Bus decode
  wire        acc     = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire        wr      = acc & wb_we_i;
  wire [1:0]  idx     = wb_adr_i[3:2];
  wire        wr_div  = wr & (idx == tw_pkg::IDX_DIV);
  wire        wr_ctrl = wr & (idx == tw_pkg::IDX_CTRL) & wb_sel_i[0];
  wire        wr_cmd  = wr & (idx == tw_pkg::IDX_CMD) & wb_sel_i[0];
  wire        wr_stat = wr & (idx == tw_pkg::IDX_STAT) & wb_sel_i[0];
  wire tw_pkg::tw_op_t cmd_op = tw_pkg::tw_op_t'(wb_dat_i[1:0]);
  wire        cmd_go  = wr_cmd & (((state_ff == tw_pkg::ST_IDLE) & (cmd_op == tw_pkg::OP_START)) |
                                  ((state_ff == tw_pkg::ST_PARK) & (cmd_op != tw_pkg::OP_START)));

  // Timing values: cur_div, cur_dh and cur_sth from the live code, the rest from values latched at command
  wire [15:0] cur_div  = tw_pkg::DIV_TAB[bit_rate_divider_code_ff];
  wire [13:0] cur_dh   = tw_pkg::dh_of(bit_rate_divider_code_ff);
  wire [11:0] cur_sth  = tw_pkg::sth_of(bit_rate_divider_code_ff);
  wire [16:0] half     = {2'b00, div_ff[15:1]};
  wire [16:0] setup    = (half > {3'b000, dh_ff}) ? half - {3'b000, dh_ff} : 17'h00001;
  wire [16:0] rs_su    = {1'b0, div_ff} + {5'h00, sth_ff};
  wire [16:0] stop_su  = (half > tw_pkg::STOP_SU_CLKS) ? half : tw_pkg::STOP_SU_CLKS;
  wire        cnt_done = (cnt_ff <= 17'h00001);

  // Bit sequencer
  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = (cnt_ff == 17'h00000) ? cnt_ff : cnt_ff - 17'h00001;
    nxt_scl_pull = scl_pull_ff;
    nxt_sda_pull = sda_pull_ff;
    case (state_ff)
      tw_pkg::ST_IDLE: begin
        if (cmd_go) begin
          nxt_state    = tw_pkg::ST_SHOLD;
          nxt_sda_pull = 1'b1;
          nxt_cnt      = {5'h00, cur_sth};
        end
      end
      tw_pkg::ST_SHOLD: begin
        if (cnt_done) begin
          nxt_state    = tw_pkg::ST_PARK;
          nxt_scl_pull = 1'b1;
        end
      end
      tw_pkg::ST_PARK: begin
        if (cmd_go) begin
          nxt_state = tw_pkg::ST_LOWH;
          nxt_cnt   = {3'b000, cur_dh};
        end
      end
      tw_pkg::ST_LOWH: begin
        if (cnt_done) begin
          nxt_state    = tw_pkg::ST_LOWS;
          nxt_sda_pull = (op_ff == tw_pkg::OP_BIT) ? ~bit_ff : (op_ff == tw_pkg::OP_STOP);
          nxt_cnt      = setup;
        end
      end
      tw_pkg::ST_LOWS: begin
        if (cnt_done) begin
          nxt_state    = tw_pkg::ST_RISE;
          nxt_scl_pull = 1'b0;
        end
      end
      tw_pkg::ST_RISE: begin
        if (scl_q) begin
          nxt_state = tw_pkg::ST_HIGH;
          case (op_ff)
            tw_pkg::OP_RSTRT: nxt_cnt = rs_su;
            tw_pkg::OP_STOP:  nxt_cnt = stop_su;
            default:          nxt_cnt = half;
          endcase
        end
      end
      tw_pkg::ST_HIGH: begin
        if (cnt_done) begin
          case (op_ff)
            tw_pkg::OP_RSTRT: begin
              nxt_state    = tw_pkg::ST_SHOLD;
              nxt_sda_pull = 1'b1;
              nxt_cnt      = {5'h00, sth_ff};
            end
            tw_pkg::OP_STOP: begin
              nxt_state    = tw_pkg::ST_IDLE;
              nxt_sda_pull = 1'b0;
            end
            default: begin
              nxt_state    = tw_pkg::ST_PARK;
              nxt_scl_pull = 1'b1;
            end
          endcase
        end
      end
      default: begin
        nxt_state    = tw_pkg::ST_IDLE;
        nxt_scl_pull = 1'b0;
        nxt_sda_pull = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff    <= tw_pkg::ST_IDLE;
      cnt_ff      <= 17'h00000;
      scl_pull_ff <= 1'b0;
      sda_pull_ff <= 1'b0;
      op_ff       <= tw_pkg::OP_START;
      bit_ff      <= 1'b1;
      rx_ff       <= 1'b1;
      div_ff      <= 16'h0000;
      dh_ff       <= 14'h0000;
      sth_ff      <= 12'h000;
      lim9_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      scl_pull_ff <= nxt_scl_pull;
      sda_pull_ff <= nxt_sda_pull;
      if (cmd_go) begin
        op_ff  <= cmd_op;
        bit_ff <= wb_dat_i[tw_pkg::CMD_BIT_POS];
        div_ff <= cur_div;
        dh_ff  <= cur_dh;
        sth_ff <= cur_sth;
        lim9_ff <= bit_rate_divider_code_ff[5];
      end
      if (state_ff == tw_pkg::ST_HIGH && cnt_done && op_ff == tw_pkg::OP_BIT) begin
        rx_ff <= sda_q;
      end
    end
  end

  // Slave clock stretch and bus monitor
  wire scl_fell  = scl_d_ff & ~scl_q;
  wire scl_rose  = ~scl_d_ff & scl_q;
  wire start_ev  = scl_q & sda_d_ff & ~sda_q;
  wire stop_ev   = scl_q & ~sda_d_ff & sda_q;
  wire slv_go    = (state_ff == tw_pkg::ST_IDLE) & stretch_ff & scl_fell & ~slv_arm_ff & ~slv_hold_ff;
  wire set_bst   = scl_fell & ev_start_ff & (mon_ff < tw_pkg::STH_IN_MIN - 3'h1);
  wire set_bsp   = stop_ev & ~ev_start_ff & (mon_ff < tw_pkg::STH_IN_MIN - 3'h1);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slv_arm_ff   <= 1'b0;
      slv_hold_ff  <= 1'b0;
      slv_cnt_ff   <= 14'h0000;
      scl_d_ff     <= 1'b1;
      sda_d_ff     <= 1'b1;
      bus_busy_ff  <= 1'b0;
      ev_start_ff  <= 1'b0;
      mon_ff       <= 3'h0;
      bad_start_ff <= 1'b0;
      bad_stop_ff  <= 1'b0;
    end else begin
      scl_d_ff <= scl_q;
      sda_d_ff <= sda_q;
      if (slv_go) begin
        slv_arm_ff <= 1'b1;
        slv_cnt_ff <= cur_dh;
      end else if (slv_arm_ff) begin
        slv_cnt_ff <= slv_cnt_ff - 14'h0001;
        if (slv_cnt_ff <= 14'h0001) begin
          slv_arm_ff  <= 1'b0;
          slv_hold_ff <= 1'b1;
        end
      end else if (!stretch_ff) begin
        slv_hold_ff <= 1'b0;
      end
      if (start_ev || scl_rose) begin
        mon_ff      <= 3'h0;
        ev_start_ff <= start_ev;
      end else if (mon_ff != 3'h7) begin
        mon_ff <= mon_ff + 3'h1;
      end
      bus_busy_ff  <= start_ev | (bus_busy_ff & ~stop_ev);
      bad_start_ff <= set_bst | (bad_start_ff & ~(wr_stat & wb_dat_i[tw_pkg::STAT_BST_POS]));
      bad_stop_ff  <= set_bsp | (bad_stop_ff & ~(wr_stat & wb_dat_i[tw_pkg::STAT_BSP_POS]));
    end
  end

  // Registers and bus answer
  wire [31:0] rdata =
    (idx == tw_pkg::IDX_DIV)  ? {18'h0, input_filter_sample_rate_ff, 2'b00, bit_rate_divider_code_ff} :
    (idx == tw_pkg::IDX_CTRL) ? {31'h0, stretch_ff} :
    (idx == tw_pkg::IDX_CMD)  ? {29'h0, bit_ff, op_ff} :
    {24'h0, slv_hold_ff, bad_stop_ff, bad_start_ff, bus_busy_ff, sda_q, scl_q, rx_ff,
     (state_ff != tw_pkg::ST_IDLE) & (state_ff != tw_pkg::ST_PARK)};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_rate_divider_code_ff    <= tw_pkg::RST_CODE;
      input_filter_sample_rate_ff <= tw_pkg::RST_RATE;
      stretch_ff                  <= 1'b0;
      ack_ff                      <= 1'b0;
      dat_ff                      <= 32'h0000_0000;
    end else begin
      ack_ff <= acc;
      if (acc) begin
        dat_ff <= wb_we_i ? 32'h0000_0000 : rdata;
      end
      if (wr_div && wb_sel_i[0]) begin
        bit_rate_divider_code_ff <= wb_dat_i[tw_pkg::DIV_CODE_LSB +: 6];
      end
      if (wr_div && wb_sel_i[1]) begin
        input_filter_sample_rate_ff <= wb_dat_i[tw_pkg::DIV_RATE_LSB +: 6];
      end
      if (wr_ctrl) begin
        stretch_ff <= wb_dat_i[0];
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe   = scl_pull_ff | slv_hold_ff;
  assign sda_oe   = sda_pull_ff;

  // Phase length helpers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stay_ff    <= 17'h00000;
      slv_len_ff <= 14'h0000;
    end else begin
      stay_ff    <= (nxt_state != state_ff) ? 17'h00000 : stay_ff + 17'h00001;
      slv_len_ff <= slv_go ? 14'h0000 : slv_len_ff + 14'h0001;
    end
  end

  wire        leave = (nxt_state != state_ff);
  wire [16:0] dur   = stay_ff + 17'h00001;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_rs_high;
    state_ff == tw_pkg::ST_HIGH && op_ff == tw_pkg::OP_RSTRT && leave;
  endsequence

  a_only_release: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("line driven high");
  a_hold_len: assert property (state_ff == tw_pkg::ST_LOWH && leave |-> dur == {3'b000, dh_ff})
    else $error("data hold length wrong");
  a_setup_len: assert property (state_ff == tw_pkg::ST_LOWS && leave && half > {3'b000, dh_ff}
    |-> dur + {3'b000, dh_ff} == half) else $error("low phase not half divider");
  a_high_len: assert property (state_ff == tw_pkg::ST_HIGH && op_ff == tw_pkg::OP_BIT && leave
    |-> dur == half ##1 scl_oe) else $error("high phase not half divider");
  a_rs_setup: assert property (s_rs_high |-> dur == rs_su ##1 sda_oe ##0 state_ff == tw_pkg::ST_SHOLD)
    else $error("repeated start setup wrong");
  a_start_hold: assert property (state_ff == tw_pkg::ST_SHOLD && leave
    |-> dur == {5'h00, sth_ff} && sth_ff < (lim9_ff ? 12'h009 : 12'h010)) else $error("start hold wrong");
  a_stop_setup: assert property (state_ff == tw_pkg::ST_HIGH && op_ff == tw_pkg::OP_STOP && leave
    |-> dur >= tw_pkg::STOP_SU_CLKS ##1 !sda_oe) else $error("stop setup too short");
  a_slave_wait: assert property ($rose(slv_hold_ff) |-> slv_len_ff == $past(slv_cnt_ff) + slv_len_ff - 14'h0001
    && slv_len_ff == cur_dh) else $error("slave stretch too early");
  a_div_map: assert property (bit_rate_divider_code_ff == 6'h20 |-> cur_div == 16'h00A0)
    else $error("divider map wrong");
endmodule
`default_nettype wire

//--- verif/tw_far_model.sv
// Far-side bus model: stretching slave, ack source and external master pulls
`timescale 1ns/1ps
`default_nettype none
module tw_far_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       scl,
  input  wire logic [7:0] stretch,
  input  wire logic       ack_en,
  input  wire logic       m_scl_low,
  input  wire logic       m_sda_low,
  output logic            scl_pull,
  output logic            sda_pull
);
  logic       scl_d_ff;
  logic [7:0] hold_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d_ff <= 1'b1;
      hold_ff  <= 8'h00;
    end else begin
      scl_d_ff <= scl;
      if (scl_d_ff && !scl) begin
        hold_ff <= stretch;
      end else if (hold_ff != 8'h00) begin
        hold_ff <= hold_ff - 8'h01;
      end
    end
  end
  // Pull low or release only
  assign scl_pull = m_scl_low | (hold_ff != 8'h00);
  assign sda_pull = m_sda_low | ack_en;
endmodule
`default_nettype wire

//--- verif/two_wire_bit_timing_and_filter_tb.sv
// Self-checking bench for the two-wire bit timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module two_wire_bit_timing_and_filter_tb;
  typedef struct {logic [5:0] code; int half; int dh; int sth; logic ack;} tw_row_t;
  logic        clk, sys_rst, wb_cyc, wb_stb, wb_we, scl_oe, sda_oe, scl_o, sda_o, wb_ack_o;
  logic [3:0]  wb_adr;
  logic [31:0] wb_dat, wb_dat_o, s;
  logic [7:0]  p_str;
  logic        p_ack, p_mscl, p_msda, p_scl, p_sda, pl_scl, pl_sda, scl_w, sda_w;
  int          num_errors, checks, cnt, t_ack, t_cmd, t_sda_rise, t_sda_fall, t_scl_rise, t_scl_fall;
  int          rise0, t0, n;
  int          hi [4];
  tw_row_t     rows [4];
  assign scl_w = ~(scl_oe | pl_scl);
  assign sda_w = ~(sda_oe | pl_sda);
  tw_core uut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
  tw_far_model far (.clk(clk), .sys_rst(sys_rst), .scl(scl_w), .stretch(p_str), .ack_en(p_ack),
    .m_scl_low(p_mscl), .m_sda_low(p_msda), .scl_pull(pl_scl), .sda_pull(pl_sda));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Edge time stamps of the pin enables
  always @(posedge clk) begin
    cnt <= cnt + 1;
    p_scl <= scl_oe;
    p_sda <= sda_oe;
    if (scl_oe === 1'b1 && p_scl === 1'b0) t_scl_rise <= cnt;
    if (scl_oe === 1'b0 && p_scl === 1'b1) t_scl_fall <= cnt;
    if (sda_oe === 1'b1 && p_sda === 1'b0) t_sda_rise <= cnt;
    if (sda_oe === 1'b0 && p_sda === 1'b1) t_sda_fall <= cnt;
    if (scl_oe === 1'b1) `CHK(scl_o, 1'b0)
    if (sda_oe === 1'b1) `CHK(sda_o, 1'b0)
  end
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    s = wb_dat_o;
    t_ack = cnt;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic cmd(input logic [1:0] op, input logic b);
    wb(1'b1, 4'h8, {29'h0, b, op});
    t_cmd = t_ack;
    do begin
      wb(1'b0, 4'hC, 32'h0);
    end while (s[0] !== 1'b0);
    repeat (2) @(posedge clk);
  endtask
  task automatic done(input string name);
    $display("test %s done, errors %0d", name, num_errors);
  endtask
  task automatic results;
    $display("checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    results();
  end
  initial begin
    {wb_cyc, wb_stb, wb_we, p_ack, p_mscl, p_msda, p_scl, p_sda} = 8'h00;
    {wb_adr, wb_dat, p_str, num_errors, checks, cnt} = '0;
    sys_rst = 1'b1;
    rows[0] = '{6'h20, 80, 24, 5, 1'b1};
    rows[1] = '{6'h21, 96, 24, 6, 1'b0};
    rows[2] = '{6'h00, 144, 56, 9, 1'b1};
    rows[3] = '{6'h01, 160, 56, 10, 1'b0};
    repeat (10) @(posedge clk);
    `CHK({scl_oe, sda_oe}, 2'b00)
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge clk);
    wb(1'b0, 4'h0, 32'h0);
    `CHK(s, 32'h0000_0100)
    wb(1'b0, 4'h4, 32'h0);
    `CHK(s, 32'h0)
    wb(1'b0, 4'hC, 32'h0);
    `CHK(s[7:0], 8'h0E)
    wb(1'b1, 4'h0, 32'hFFFF_C020);
    wb(1'b0, 4'h1, 32'h0);
    `CHK(s, 32'h0000_0020)
    done("reset");
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 4'h0, {18'h0, 6'h01, 2'h0, rows[i].code});
      cmd(2'h0, 1'b0);
      `CHK(t_scl_rise - t_sda_rise, rows[i].sth)
      rise0 = t_scl_rise;
      p_ack <= rows[i].ack;
      cmd(2'h1, 1'b1);
      `CHK((t_sda_fall - t_cmd) inside {[rows[i].dh - 1:rows[i].dh + 2]}, 1'b1)
      `CHK(t_scl_fall - t_sda_fall >= rows[i].half - rows[i].dh, 1'b1)
      `CHK(t_scl_fall - rise0 >= rows[i].half, 1'b1)
      hi[i] = t_scl_rise - t_scl_fall;
      `CHK((hi[i] - rows[i].half) inside {[1:12]}, 1'b1)
      wb(1'b0, 4'hC, 32'h0);
      `CHK(s[1], ~rows[i].ack)
      p_ack <= 1'b0;
      cmd(2'h3, 1'b0);
      `CHK(t_sda_fall - t_scl_fall >= 4, 1'b1)
      `CHK(t_sda_fall - t_scl_fall >= rows[i].half, 1'b1)
      done("row");
    end
    `CHK(hi[1] - hi[0], 16)
    `CHK(hi[3] - hi[2], 16)
    wb(1'b1, 4'h0, 32'h0000_0120);
    cmd(2'h0, 1'b0);
    cmd(2'h1, 1'b1);
    cmd(2'h2, 1'b0);
    `CHK(t_sda_rise - t_scl_fall >= 165, 1'b1)
    `CHK(t_scl_rise - t_sda_rise, 5)
    cmd(2'h3, 1'b0);
    done("repeated start");
    p_str <= 8'd200;
    cmd(2'h0, 1'b0);
    rise0 = t_scl_rise;
    cmd(2'h1, 1'b1);
    `CHK(t_scl_rise - rise0 >= 280, 1'b1)
    p_str <= 8'd0;
    cmd(2'h3, 1'b0);
    done("stretch");
    wb(1'b1, 4'h0, 32'h0000_0820);
    p_mscl <= 1'b1;
    wb(1'b0, 4'hC, 32'h0);
    `CHK(s[2], 1'b1)
    repeat (23) @(posedge clk);
    wb(1'b0, 4'hC, 32'h0);
    `CHK(s[2], 1'b0)
    p_mscl <= 1'b0;
    repeat (40) @(posedge clk);
    done("filter");
    wb(1'b1, 4'h0, 32'h0000_0120);
    wb(1'b1, 4'h4, 32'h1);
    @(posedge clk);
    p_mscl <= 1'b1;
    t0 = cnt;
    n = 0;
    while (scl_oe !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    `CHK(cnt - t0 >= 24, 1'b1)
    p_mscl <= 1'b0;
    wb(1'b0, 4'hC, 32'h0);
    `CHK(s[7], 1'b1)
    wb(1'b1, 4'h4, 32'h0);
    repeat (5) @(posedge clk);
    `CHK(scl_oe, 1'b0)
    repeat (20) @(posedge clk);
    done("slave hold");
    p_msda <= 1'b1;
    repeat (3) @(posedge clk);
    p_mscl <= 1'b1;
    repeat (40) @(posedge clk);
    p_mscl <= 1'b0;
    repeat (3) @(posedge clk);
    p_msda <= 1'b0;
    repeat (20) @(posedge clk);
    wb(1'b0, 4'hC, 32'h0);
    `CHK(s[6:5], 2'b11)
    wb(1'b1, 4'hC, 32'h60);
    wb(1'b0, 4'hC, 32'h0);
    `CHK(s[6:5], 2'b00)
    done("short start and stop");
    results();
  end
endmodule
`default_nettype wire
